// ---- logic/tmc_pkg.sv ----
// Package: register map, field layout and encodings of the timer core
package tmc_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned BYTE_W = 8;

   // Register offsets
   localparam logic [3:0] REG_CTRL0 = 4'h0;
   localparam logic [3:0] REG_CTRL1 = 4'h1;
   localparam logic [3:0] REG_CNTL  = 4'h2;
   localparam logic [3:0] REG_CNTH  = 4'h3;
   localparam logic [3:0] REG_CMPAL = 4'h4;
   localparam logic [3:0] REG_CMPAH = 4'h5;
   localparam logic [3:0] REG_PERL  = 4'h6;
   localparam logic [3:0] REG_PERH  = 4'h7;
   localparam logic [3:0] REG_STAT  = 4'h8;

   // Control 0 fields
   localparam int unsigned C0_PAUSE  = 7;
   localparam int unsigned C0_CKS_HI = 6;
   localparam int unsigned C0_CKS_LO = 4;
   localparam int unsigned C0_ON     = 3;
   // Control 1 fields
   localparam int unsigned C1_MODE_HI = 7;
   localparam int unsigned C1_MODE_LO = 6;
   localparam int unsigned C1_IO_HI   = 5;
   localparam int unsigned C1_IO_LO   = 4;
   localparam int unsigned C1_OC      = 3;
   localparam int unsigned C1_POL     = 2;
   localparam int unsigned C1_CCLR    = 0;
   // Status fields
   localparam int unsigned ST_A   = 0;
   localparam int unsigned ST_P   = 1;
   localparam int unsigned ST_OVF = 2;

   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE  = 16'h0001;
   localparam logic [15:0] CNT_MAX  = 16'hffff;

   // Clock select encodings
   localparam logic [2:0] CKS_SYS4  = 3'h0;
   localparam logic [2:0] CKS_SYS   = 3'h1;
   localparam logic [2:0] CKS_H16   = 3'h2;
   localparam logic [2:0] CKS_H64   = 3'h3;
   localparam logic [2:0] CKS_SUBA  = 3'h4;
   localparam logic [2:0] CKS_SUBB  = 3'h5;
   localparam logic [2:0] CKS_PINR  = 3'h6;
   localparam logic [2:0] CKS_PINF  = 3'h7;

   // Modes
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;

   // Output actions
   localparam logic [1:0] IO_NONE   = 2'h0;
   localparam logic [1:0] IO_LOW    = 2'h1;
   localparam logic [1:0] IO_HIGH   = 2'h2;
   localparam logic [1:0] IO_TOGGLE = 2'h3;
   localparam logic [1:0] IO_PWM    = 2'h2;
   localparam logic [1:0] IO_SPULSE = 2'h3;

   // Prescale dividers
   localparam logic [5:0] DIV4  = 6'h03;
   localparam logic [5:0] DIV16 = 6'h0f;
   localparam logic [5:0] DIV64 = 6'h3f;
endpackage : tmc_pkg

// ---- logic/tmc_core.sv ----
// Timer core: counter, comparators, output pin and byte access
//
// Contract
// - A free-running up counter is compared with both comparators and a match raises an interrupt, may clear the counter and may change the output pin.
// - A three-bit select chooses the count clock among system clock ratios, high clock ratios, subsidiary clock or the input pin.
// - Comparator A and comparator P each raise their own interrupt on their own match.
// - With the input pin selected the counter steps on the rising or falling pin edge as chosen.
// - In single pulse mode the input pin edge is the trigger that starts the pulse.
// - In compare match mode a comparator A match drives the output high, low or toggles it as configured.
// - In PWM mode with output action IO_PWM the output pin carries the PWM waveform.
// - High bytes are accessed directly while low bytes pass through one shared byte buffer moved only on high byte access.
// - A write to a compare low byte stores only into the buffer.
// - A write to the comparator A high byte updates it and copies the buffer into the low byte at once; a period high byte write sets only the eight-bit period.
// - A read of a high byte returns it and captures the matching low byte into the buffer, or zero on a period high byte read.
// - A read of a low byte returns the buffer.
// - The counter is sixteen bits wide and counts up.
// - The counter clears on overflow and on a match with a clearing comparator.
`timescale 1ns/1ps
`default_nettype none
module tmc_core
   import tmc_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output var  logic [7:0]        o_rdata,
   input  wire logic              i_high_clk_en,
   input  wire logic              i_sub_clk_en,
   input  wire logic              i_timer_clock_input_pin,
   output var  logic              o_timer_output_pin,
   output var  logic              o_irq_a,
   output var  logic              o_irq_p
);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  ctrl0_r;
   logic [7:0]  ctrl1_r;
   logic [15:0] cnt_r;
   logic [15:0] cmp_a_r;
   logic [7:0]  per_r;
   logic [7:0]  buf_r;
   logic [2:0]  stat_r;
   logic [5:0]  sys_div_r;
   logic [5:0]  h_div_r;
   logic [2:0]  pin_sync_r;
   logic        on_d_r;
   logic        out_r;
   logic        pulse_run_r;

   logic [2:0]  cks;
   logic [1:0]  mode;
   logic [1:0]  io;
   logic        on;
   logic        on_rise;
   logic        tick;
   logic        pin_edge;
   logic        match_a;
   logic        match_p;
   logic        ovf;
   logic        step;
   logic        spulse;

   assign cks    = ctrl0_r[C0_CKS_HI:C0_CKS_LO];
   assign on     = ctrl0_r[C0_ON];
   assign mode   = ctrl1_r[C1_MODE_HI:C1_MODE_LO];
   assign io     = ctrl1_r[C1_IO_HI:C1_IO_LO];
   assign on_rise = on & ~on_d_r;
   assign spulse = (mode == MODE_PWM) && (io == IO_SPULSE);

   function automatic logic is_wr(input logic [3:0] a);
      is_wr = i_wr && (i_addr == a);
   endfunction : is_wr

   function automatic logic is_rd(input logic [3:0] a);
      is_rd = i_rd && (i_addr == a);
   endfunction : is_rd

   ////////////////////////////////////////////////////////////////////////
   // Prescalers run freely so ratio changes take effect promptly
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         sys_div_r <= 6'h00;
      end else begin
         sys_div_r <= sys_div_r + 6'h01;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         h_div_r <= 6'h00;
      end else if (i_high_clk_en) begin
         h_div_r <= h_div_r + 6'h01;
      end
   end

   // Only the second and third stages feed the edge detector
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         pin_sync_r <= 3'h0;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], i_timer_clock_input_pin};
      end
   end

   always_comb begin
      pin_edge = (cks == CKS_PINF) ? (pin_sync_r[2] & ~pin_sync_r[1])
                                   : (~pin_sync_r[2] & pin_sync_r[1]);
   end

   always_comb begin
      unique case (cks)
         CKS_SYS4: tick = (sys_div_r[1:0] == DIV4[1:0]);
         CKS_SYS:  tick = 1'b1;
         CKS_H16:  tick = i_high_clk_en && (h_div_r[3:0] == DIV16[3:0]);
         CKS_H64:  tick = i_high_clk_en && (h_div_r == DIV64);
         CKS_SUBA, CKS_SUBB: tick = i_sub_clk_en;
         CKS_PINR, CKS_PINF: tick = pin_edge;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // No step on the enabling edge, so a stale count never matches
   assign step    = on && !ctrl0_r[C0_PAUSE] && tick
                    && (!spulse || pulse_run_r) && !on_rise;
   assign match_a = step && (cnt_r == cmp_a_r);
   assign match_p = step && (cnt_r[15:8] == per_r);
   assign ovf     = step && (cnt_r == CNT_MAX);

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         on_d_r <= 1'b0;
      end else begin
         on_d_r <= on;
      end
   end

   // Counter; clearing comparator chosen by the clear bit
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_r <= CNT_ZERO;
      end else if (on_rise) begin
         cnt_r <= CNT_ZERO;
      end else if (step) begin
         if (ovf) begin
            cnt_r <= CNT_ZERO;
         end else if (ctrl1_r[C1_CCLR] ? match_a : match_p) begin
            cnt_r <= CNT_ZERO;
         end else begin
            cnt_r <= cnt_r + CNT_ONE;
         end
      end
   end

   // Single pulse: pin edge starts, match A ends
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         pulse_run_r <= 1'b0;
      end else if (!spulse || !on || on_rise || match_a) begin
         pulse_run_r <= 1'b0;
      end else if (pin_edge) begin
         pulse_run_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin; polarity applied at the pin
   logic out_nxt;
   always_comb begin
      out_nxt = out_r;
      if (!on || on_rise) begin
         out_nxt = ctrl1_r[C1_OC];
      end else if (mode == MODE_CMP) begin
         if (match_a) begin
            unique case (io)
               IO_NONE:   out_nxt = out_r;
               IO_LOW:    out_nxt = 1'b0;
               IO_HIGH:   out_nxt = 1'b1;
               IO_TOGGLE: out_nxt = ~out_r;
            endcase
         end
      end else if (mode == MODE_PWM) begin
         unique case (io)
            IO_NONE: out_nxt = ~ctrl1_r[C1_OC];
            IO_LOW:  out_nxt = ctrl1_r[C1_OC];
            IO_PWM: begin
               if (match_p || ovf || cnt_r == CNT_ZERO) begin
                  out_nxt = ctrl1_r[C1_OC];
               end else if (match_a) begin
                  out_nxt = ~ctrl1_r[C1_OC];
               end
            end
            IO_SPULSE: begin
               if (pin_edge && !pulse_run_r) begin
                  out_nxt = ctrl1_r[C1_OC];
               end else if (match_a) begin
                  out_nxt = ~ctrl1_r[C1_OC];
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_timer_output_pin <= 1'b0;
      end else begin
         o_timer_output_pin <= out_nxt ^ ctrl1_r[C1_POL];
      end
   end

   // Interrupt pulses, one cycle per match
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_irq_a <= 1'b0;
         o_irq_p <= 1'b0;
      end else begin
         o_irq_a <= match_a;
         o_irq_p <= match_p;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ctrl0_r <= CTRL0_RST;
      end else if (is_wr(REG_CTRL0)) begin
         ctrl0_r <= {i_wdata[7:3], 3'h0};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ctrl1_r <= CTRL1_RST;
      end else if (is_wr(REG_CTRL1)) begin
         ctrl1_r <= i_wdata;
      end
   end

   // Low compare bytes land only via high byte writes
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cmp_a_r <= CNT_ZERO;
      end else if (is_wr(REG_CMPAH)) begin
         cmp_a_r <= {i_wdata, buf_r};
      end
   end

   // Period comparator is eight bits; its low byte has no match effect
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         per_r <= BYTE_ZERO;
      end else if (is_wr(REG_PERH)) begin
         per_r <= i_wdata;
      end
   end

   // Shared holding byte; misordered access corrupts it by design
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         buf_r <= BYTE_ZERO;
      end else if (is_wr(REG_CMPAL) || is_wr(REG_PERL)) begin
         buf_r <= i_wdata;
      end else if (is_rd(REG_CNTH)) begin
         buf_r <= cnt_r[7:0];
      end else if (is_rd(REG_CMPAH)) begin
         buf_r <= cmp_a_r[7:0];
      end else if (is_rd(REG_PERH)) begin
         buf_r <= BYTE_ZERO;
      end
   end

   // Sticky status, set wins over clear by write of ones
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         stat_r <= 3'h0;
      end else begin
         stat_r <= (is_wr(REG_STAT) ? stat_r & ~i_wdata[2:0] : stat_r)
                   | {ovf, match_p, match_a};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_rdata <= BYTE_ZERO;
      end else if (i_rd) begin
         unique case (i_addr)
            REG_CTRL0: o_rdata <= ctrl0_r;
            REG_CTRL1: o_rdata <= ctrl1_r;
            REG_CNTL, REG_CMPAL, REG_PERL: o_rdata <= buf_r;
            REG_CNTH:  o_rdata <= cnt_r[15:8];
            REG_CMPAH: o_rdata <= cmp_a_r[15:8];
            REG_PERH:  o_rdata <= per_r;
            REG_STAT:  o_rdata <= {5'h00, stat_r};
            default:   o_rdata <= BYTE_ZERO;
         endcase
      end else begin
         o_rdata <= BYTE_ZERO;
      end
   end

endmodule : tmc_core
`default_nettype wire

// ---- testbench/tmc_core_properties.sv ----
// Checker: port-level properties of the timer core
`timescale 1ns/1ps
`default_nettype none
module tmc_core_properties
   import tmc_pkg::*;
(
   input wire logic              i_core_clk,
   input wire logic              i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0]        i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [7:0]        o_rdata,
   input wire logic              o_timer_output_pin,
   input wire logic              o_irq_a,
   input wire logic              o_irq_p
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////
   a_reset_quiet: assert property ($rose(i_rst_n) |->
      !(o_irq_a | o_irq_p | o_timer_output_pin) && o_rdata == 8'h00)
      else $error("outputs busy after reset");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   a_unmapped_zero: assert property (
      i_rd && i_addr > REG_STAT |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_clock_select: assert property (
      i_wr && i_addr == REG_CTRL0 ##1 i_rd && i_addr == REG_CTRL0
      |=> o_rdata == {$past(i_wdata[7:3], 2), 3'h0})
      else $error("control readback wrong");
   a_shared_buffer: assert property (
      i_wr && i_addr == REG_CMPAL ##1 i_rd && i_addr == REG_CNTL
      |=> o_rdata == $past(i_wdata, 2)) else $error("buffer missed");
   a_pair_access: assert property (
      i_wr && i_addr == REG_CMPAL ##1 i_wr && i_addr == REG_CMPAH
      ##1 i_rd && i_addr == REG_CMPAH ##1 i_rd && i_addr == REG_CMPAL
      |=> o_rdata == $past(i_wdata, 4)) else $error("pair mismatch");
   a_high_read: assert property (
      i_wr && i_addr == REG_CMPAH ##1 i_rd && i_addr == REG_CMPAH
      |=> o_rdata == $past(i_wdata, 2)) else $error("high readback");
   a_low_repeat: assert property (
      i_rd && i_addr == REG_CNTL ##1 i_rd && i_addr == REG_CNTL
      |=> o_rdata == $past(o_rdata)) else $error("low not buffered");
   a_status_a: assert property (
      o_irq_a ##1 i_rd && i_addr == REG_STAT |=> o_rdata[ST_A])
      else $error("match A not recorded");
endmodule : tmc_core_properties
bind tmc_core tmc_core_properties u_tmc_core_properties (.*);
`default_nettype wire

// ---- testbench/tmc_ext_src.sv ----
// Partner: external count source feeding the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tmc_ext_src (
   input  wire logic i_core_clk,
   input  wire logic i_level,
   input  wire logic i_slow,
   output var  logic o_pin
);
   logic [1:0] lag_r = 2'h0;
   // Slow mode adds a cycle of wire delay
   always_ff @(posedge i_core_clk) begin
      lag_r <= {lag_r[0], i_level};
   end
   assign o_pin = i_slow ? lag_r[1] : lag_r[0];
endmodule : tmc_ext_src
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Testbench: directed scenarios for the timer core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tmc_pkg::*;
   logic              i_core_clk = 1'b0;
   logic              i_rst_n = 1'b0;
   logic [ADDR_W-1:0] i_addr = 4'h0;
   logic [7:0]        i_wdata = 8'h00;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic              i_high_clk_en = 1'b0;
   logic              i_sub_clk_en = 1'b0;
   logic              ext_level = 1'b0;
   logic              ext_slow = 1'b0;
   logic              pin_in;
   logic [7:0]        o_rdata;
   logic              o_pin;
   logic              o_irq_a;
   logic              o_irq_p;
   logic [7:0]        hi;
   logic [7:0]        lo;
   int                mismatches = 0;
   int                checks_done = 0;
   int                cycles = 0;
   always #4 i_core_clk = ~i_core_clk;
   tmc_core u_tmc_core (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_high_clk_en(i_high_clk_en),
      .i_sub_clk_en(i_sub_clk_en), .i_timer_clock_input_pin(pin_in),
      .o_timer_output_pin(o_pin), .o_irq_a(o_irq_a), .o_irq_p(o_irq_p));
   tmc_ext_src u_tmc_ext_src (.i_core_clk(i_core_clk),
      .i_level(ext_level), .i_slow(ext_slow), .o_pin(pin_in));
   ////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   // Enables kept toggling so prescaler paths are not frozen
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      i_high_clk_en <= cycles[1:0] == 2'b00;
      i_sub_clk_en <= cycles[4:0] == 5'h00;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : tick
   task automatic bus(input logic w, r, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge i_core_clk);
      i_wr <= w;
      i_rd <= r;
      i_addr <= a;
      i_wdata <= d;
   endtask : bus
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, 8'h00);
   endtask : wr8
   // Strobe left high so a read may follow at once
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      bus(1'b1, 1'b0, a, v[7:0]);
      bus(1'b1, 1'b0, a + 4'h1, v[15:8]);
   endtask : wr16
   task automatic rd2(input logic [3:0] a, b);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b1, b, 8'h00);
      #1;
      hi = o_rdata;
      bus(1'b0, 1'b0, b, 8'h00);
      #1;
      lo = o_rdata;
   endtask : rd2
   task automatic wait_irq(input logic on_p);
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
      end while ((on_p ? o_irq_p : o_irq_a) !== 1'b1 && n < 600);
      chk("irq", 16'h0001, 16'(n < 600));
   endtask : wait_irq
   ////////////////////////////////////////
   task automatic t_regs();
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 1'b0, 4'hf, 8'hff);
         bus(1'b1, 1'b0, REG_CTRL0, {1'b0, 3'(k), 4'h7});
         rd2(REG_CTRL0, 4'hf);
         chk("ctrl0", {1'b0, 3'(k), 4'h0}, hi);
         chk("unmapped", 16'h0000, lo);
      end
      $display("test regs done");
   endtask : t_regs
   task automatic t_cmp();
      wr16(REG_CMPAL, 16'h2211);
      rd2(REG_CMPAH, REG_CMPAL);
      chk("cmpa high", 16'h0022, hi);
      chk("cmpa low", 16'h0011, lo);
      bus(1'b1, 1'b0, REG_CMPAL, 8'h33);
      rd2(REG_CNTL, REG_CMPAH);
      chk("buffer", 16'h0033, hi);
      chk("high kept", 16'h0022, lo);
      rd2(REG_CMPAL, REG_PERH);
      chk("low kept", 16'h0011, hi);
      chk("period high", 16'h0000, lo);
      $display("test cmp done");
   endtask : t_cmp
   task automatic t_count();
      int   t0;
      logic p1;
      wr8(REG_CTRL1, 8'h31);
      wr16(REG_CMPAL, 16'h0002);
      wr8(REG_CTRL0, 8'h18);
      wait_irq(1'b0);
      t0 = cycles;
      tick(2);
      p1 = o_pin;
      wait_irq(1'b0);
      chk("period", 16'h0003, 16'(cycles - t0));
      tick(2);
      chk("toggle", {15'h0, ~p1}, {15'h0, o_pin});
      rd2(REG_CNTL, REG_CNTL);
      chk("low buffered", 16'h0002, hi);
      chk("low twice", hi, lo);
      rd2(REG_CNTH, REG_CNTL);
      chk("count high", 16'h0000, hi);
      chk("count", 16'h0001, 16'(lo <= 8'h02));
      $display("test count done");
   endtask : t_count
   task automatic t_pwm();
      wr8(REG_CTRL0, 8'h10);
      wr8(REG_CTRL1, 8'ha0);
      wr8(REG_STAT, 8'h07);
      wr16(REG_CMPAL, 16'h0040);
      wr16(REG_PERL, 16'h0100);
      wr8(REG_CTRL0, 8'h18);
      wait_irq(1'b0);
      rd2(REG_STAT, REG_STAT);
      chk("status a", 16'h0001, hi[ST_A]);
      chk("status p", 16'h0000, hi[ST_P]);
      chk("pwm on", 16'h0001, o_pin);
      wait_irq(1'b1);
      tick(2);
      chk("pwm off", 16'h0000, o_pin);
      $display("test pwm done");
   endtask : t_pwm
   task automatic t_edge(input logic [2:0] cks, input logic [15:0] first);
      int n;
      n = 0;
      wr8(REG_CTRL0, {1'b0, cks, 4'h0});
      wr8(REG_CTRL1, 8'h01);
      wr16(REG_CMPAL, 16'h0002);
      wr8(REG_CTRL0, {1'b0, cks, 4'h8});
      for (int k = 0; k < 6; k++) begin
         if (k == 5) chk("edges", first, 16'(n));
         @(posedge i_core_clk);
         ext_level <= ~ext_level;
         for (int c = 0; c < 7; c++) begin
            tick(1);
            n += o_irq_a;
         end
      end
      chk("edges all", 16'h0001, 16'(n));
      $display("test edge done");
   endtask : t_edge
   task automatic t_pulse();
      int n;
      n = 0;
      wr8(REG_CTRL0, 8'h10);
      wr8(REG_CTRL1, 8'hb0);
      wr16(REG_CMPAL, 16'h0005);
      wr8(REG_CTRL0, 8'h18);
      for (int c = 0; c < 20; c++) begin
         tick(1);
         n += o_irq_a;
      end
      chk("idle", 16'h0000, 16'(n));
      chk("pulse idle", 16'h0000, {15'h0, o_pin});
      @(posedge i_core_clk);
      ext_level <= 1'b1;
      wait_irq(1'b0);
      chk("pulse end", 16'h0001, {15'h0, o_pin});
      $display("test pulse done");
   endtask : t_pulse
   // Polarity, drive high on match, and pause holding the count
   task automatic t_hold();
      int n;
      n = 0;
      wr8(REG_CTRL0, 8'h10);
      wr8(REG_CTRL1, 8'h25);
      wr16(REG_CMPAL, 16'h0002);
      wr8(REG_CTRL0, 8'h18);
      tick(1);
      chk("pol start", 16'h0001, {15'h0, o_pin});
      wait_irq(1'b0);
      chk("pol high", 16'h0000, {15'h0, o_pin});
      wr8(REG_CTRL0, 8'h98);
      for (int c = 0; c < 20; c++) begin
         tick(1);
         n += o_irq_a;
      end
      chk("paused", 16'h0000, 16'(n));
      wr8(REG_CTRL0, 8'h18);
      wait_irq(1'b0);
      $display("test hold done");
   endtask : t_hold
   // Match period is the clock ratio times compare value plus one
   task automatic t_rate(input logic [2:0] cks, input logic [15:0] cmp,
                         input int period);
      int t0;
      wr8(REG_CTRL0, {1'b0, cks, 4'h0});
      wr8(REG_CTRL1, 8'h01);
      wr16(REG_CMPAL, cmp);
      wr8(REG_CTRL0, {1'b0, cks, 4'h8});
      wait_irq(1'b0);
      t0 = cycles;
      wait_irq(1'b0);
      chk("rate", 16'(period), 16'(cycles - t0));
      $display("test rate done");
   endtask : t_rate
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_cmp();
      t_count();
      t_pwm();
      t_edge(CKS_PINR, 16'h0001);
      ext_slow <= 1'b1;
      t_edge(CKS_PINF, 16'h0000);
      t_pulse();
      t_hold();
      t_rate(CKS_SYS4, 16'h0002, 12);
      t_rate(CKS_H16, 16'h0002, 192);
      t_rate(CKS_H64, 16'h0000, 256);
      t_rate(CKS_SUBB, 16'h0002, 96);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
